/* shared/halt_cmd_pkg.sv */
`default_nettype none
package halt_cmd_pkg;
  // Register byte addresses, one aligned 32-bit word each
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TARGET = 8'h04;
  localparam logic [7:0] ADDR_ACTUAL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam int ADDR_W = 8;
  localparam int POS_W = 16;

  // Control word layout
  localparam int CTRL_NODE_LSB = 0;
  localparam int NODE_W = 7;
  localparam int CTRL_ENABLE_BIT = 8;
  localparam logic [6:0] NODE_ADDR_RESET = 7'h00;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam logic [15:0] TARGET_RESET = 16'h0000;

  // Status word layout
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_SRC_THERMAL_BIT = 4;
  localparam int STAT_IGNORED_BIT = 8;
  localparam int STAT_THERMAL_LEVEL_BIT = 9;
  localparam int STAT_MOVING_BIT = 10;

  // Halt frame layout
  localparam logic [3:0] HALT_FRAME_BYTES = 4'h2;
  localparam int CMD_MARK_BIT = 7;
  localparam logic [6:0] HALT_CMD_CODE = 7'h0f;
  localparam int BROADCAST_BIT = 7;
  localparam logic BROADCAST_ALL = 1'b0;

  typedef enum logic [1:0] {ST_IDLE, ST_DECEL, ST_STOP, ST_LOAD} halt_state_e;
endpackage : halt_cmd_pkg
`default_nettype wire

/* logic/rise_detect.sv */
`timescale 1ns/10ps
`default_nettype none
module rise_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level,
  output logic pulse
);
  logic level_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= level;
    end
  end

  assign pulse = level & ~level_reg;
endmodule : rise_detect
`default_nettype wire

/* logic/halt_frame_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module halt_frame_decode (
  input wire logic frame_valid,
  input wire logic [3:0] frame_byte_count,
  input wire logic [7:0] frame_data1,
  input wire logic [7:0] frame_data2,
  input wire logic [halt_cmd_pkg::NODE_W-1:0] node_address,
  output logic frame_hit
);
  import halt_cmd_pkg::*;

  // Identifier is deliberately not an input: only the data decides
  wire logic is_type1 = frame_byte_count == HALT_FRAME_BYTES;
  wire logic is_cmd = frame_data1[CMD_MARK_BIT] && (frame_data1[NODE_W-1:0] == HALT_CMD_CODE);
  wire logic to_all = frame_data2[BROADCAST_BIT] == BROADCAST_ALL;
  wire logic to_me = frame_data2[NODE_W-1:0] == node_address;

  assign frame_hit = frame_valid && is_type1 && is_cmd && (to_all || to_me);
endmodule : halt_frame_decode
`default_nettype wire

/* logic/lin_soft_stop_command.sv */
`timescale 1ns/10ps
`default_nettype none
module lin_soft_stop_command (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [halt_cmd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_valid,
  input wire logic [3:0] frame_byte_count,
  input wire logic [7:0] frame_data1,
  input wire logic [7:0] frame_data2,
  input wire logic thermal_shutdown,
  input wire logic two_stage_reference_move,
  input wire logic motion_busy,
  input wire logic at_min_velocity,
  input wire logic [halt_cmd_pkg::POS_W-1:0] actual_position,
  output logic decel_to_min,
  output logic stop_motor,
  output logic halt_done,
  output logic [halt_cmd_pkg::POS_W-1:0] target_position
);
  import halt_cmd_pkg::*;

  halt_state_e state_reg, state_next;
  logic [NODE_W-1:0] node_reg;
  logic enable_reg;
  logic [POS_W-1:0] target_reg;
  logic ignored_reg;
  logic src_thermal_reg;
  logic decel_reg, stop_reg, done_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  logic frame_hit, thermal_rise;

  halt_frame_decode u_decode (
    .frame_valid(frame_valid),
    .frame_byte_count(frame_byte_count),
    .frame_data1(frame_data1),
    .frame_data2(frame_data2),
    .node_address(node_reg),
    .frame_hit(frame_hit)
  );

  // Level stays high for the whole overheat; one halt per rise
  rise_detect u_thermal (
    .pclk(pclk),
    .presetn(presetn),
    .level(thermal_shutdown),
    .pulse(thermal_rise)
  );

  // Request decode
  wire logic request_now = frame_hit || thermal_rise;
  wire logic idle = state_reg == ST_IDLE;
  wire logic accept = request_now && idle && enable_reg && motion_busy && !two_stage_reference_move;
  wire logic refuse = request_now && two_stage_reference_move;

  // Halt sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          state_next = ST_DECEL;
        end
      end
      ST_DECEL: begin
        if (at_min_velocity || !motion_busy) begin
          state_next = ST_STOP;
        end
      end
      ST_STOP: begin
        if (!motion_busy) begin
          state_next = ST_LOAD;
        end
      end
      ST_LOAD: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // APB decode
  wire logic apb_access = psel && penable;
  wire logic apb_done = apb_access && pready_reg;
  wire logic hit_ctrl = paddr == ADDR_CTRL;
  wire logic hit_target = paddr == ADDR_TARGET;
  wire logic hit_actual = paddr == ADDR_ACTUAL;
  wire logic hit_status = paddr == ADDR_STATUS;
  wire logic mapped = hit_ctrl || hit_target || hit_actual || hit_status;
  wire logic wr_ctrl = apb_done && pwrite && hit_ctrl;
  wire logic wr_target = apb_done && pwrite && hit_target;
  wire logic wr_status = apb_done && pwrite && hit_status;
  wire logic clr_ignored = wr_status && pwdata[STAT_IGNORED_BIT];

  wire logic [31:0] ctrl_word = {23'h000000, enable_reg, 1'b0, node_reg};
  wire logic [31:0] status_word = {21'h000000, motion_busy, thermal_shutdown, ignored_reg,
                                   3'h0, src_thermal_reg, 2'h0, state_reg};
  wire logic [31:0] read_word = hit_ctrl ? ctrl_word :
                                hit_target ? {16'h0000, target_reg} :
                                hit_actual ? {16'h0000, actual_position} :
                                hit_status ? status_word : 32'h00000000;

  // One wait state: pready rises on the second access cycle
  wire logic pready_next = apb_access && !pready_reg;
  wire logic [31:0] prdata_next = pready_next && !pwrite ? read_word : 32'h00000000;
  wire logic pslverr_next = pready_next && !mapped;

  // Hardware load beats a software write landing in the same cycle
  wire logic load_target = state_reg == ST_LOAD;
  wire logic [POS_W-1:0] target_next = load_target ? actual_position :
                                       wr_target ? pwdata[POS_W-1:0] : target_reg;
  wire logic ignored_next = refuse || (ignored_reg && !clr_ignored);
  wire logic src_thermal_next = accept ? thermal_rise : src_thermal_reg;
  wire logic decel_next = state_next == ST_DECEL;
  wire logic stop_next = state_next == ST_STOP;
  wire logic done_next = load_target;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      decel_reg <= 1'b0;
      stop_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      decel_reg <= decel_next;
      stop_reg <= stop_next;
      done_reg <= done_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_reg <= TARGET_RESET;
      ignored_reg <= 1'b0;
      src_thermal_reg <= 1'b0;
    end else begin
      target_reg <= target_next;
      ignored_reg <= ignored_next;
      src_thermal_reg <= src_thermal_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      node_reg <= NODE_ADDR_RESET;
      enable_reg <= CTRL_ENABLE_RESET;
    end else if (wr_ctrl) begin
      node_reg <= pwdata[CTRL_NODE_LSB +: NODE_W];
      enable_reg <= pwdata[CTRL_ENABLE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= pready_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign decel_to_min = decel_reg;
  assign stop_motor = stop_reg;
  assign halt_done = done_reg;
  assign target_position = target_reg;

  // Checks
  decel_on_accept_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept |=> decel_to_min && !stop_motor && state_reg == ST_DECEL)
    else $error("accepted halt did not start deceleration");

  stop_after_min_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ST_DECEL && at_min_velocity && motion_busy) |=> stop_motor ##1 (stop_motor || !decel_to_min))
    else $error("no stop after reaching minimum velocity");

  target_holds_stop_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ST_STOP && !motion_busy) |=> ##1 (target_position == $past(actual_position) && halt_done))
    else $error("target not loaded with actual position after stop");

  data_only_decode_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (frame_valid && frame_byte_count == HALT_FRAME_BYTES && frame_data1 == {1'b1, HALT_CMD_CODE}
     && !frame_data2[BROADCAST_BIT]) |-> request_now)
    else $error("halt frame data not recognised");

  two_stage_ignore_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (idle && two_stage_reference_move) |=> (state_reg == ST_IDLE && !decel_to_min))
    else $error("halt taken during two-stage move");

  thermal_halt_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($rose(thermal_shutdown) && idle && enable_reg && motion_busy && !two_stage_reference_move)
    |=> state_reg == ST_DECEL)
    else $error("thermal rise did not raise halt");

  frame_format_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    frame_hit |-> (frame_byte_count == HALT_FRAME_BYTES && frame_data1[CMD_MARK_BIT]
                   && frame_data1[NODE_W-1:0] == HALT_CMD_CODE))
    else $error("frame accepted with wrong format");

  broadcast_all_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (frame_valid && frame_byte_count == HALT_FRAME_BYTES && frame_data1 == {1'b1, HALT_CMD_CODE}
     && frame_data2[BROADCAST_BIT] == BROADCAST_ALL && frame_data2[NODE_W-1:0] != node_reg) |-> frame_hit)
    else $error("broadcast halt refused by address");

  address_filter_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (frame_valid && frame_data2[BROADCAST_BIT] && frame_data2[NODE_W-1:0] != node_reg) |-> !frame_hit)
    else $error("addressed halt taken by wrong node");

  apb_one_wait_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($rose(psel && penable)) |-> !pready ##1 pready)
    else $error("APB answer not after one wait state");

  // Bus answer shape
  pready_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("APB ready held for more than one cycle");

  read_idle_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h00000000)
    else $error("read data not zero outside the answer cycle");

  bus_error_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (apb_access && !pready) |=> (pready && pslverr == !$past(mapped)))
    else $error("APB error flag does not match address decode");

  // Sequencer holding and refusal
  decel_holds_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ST_DECEL && !at_min_velocity && motion_busy) |=> (decel_to_min && state_reg == ST_DECEL))
    else $error("deceleration left before minimum velocity");

  stop_holds_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ST_STOP && motion_busy) |=> (stop_motor && !decel_to_min))
    else $error("stop released while motor still moving");

  rest_ignore_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (idle && !motion_busy) |=> state_reg == ST_IDLE)
    else $error("halt started with motor at rest");

  disabled_ignore_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (idle && !enable_reg) |=> state_reg == ST_IDLE)
    else $error("halt started while halt enable is off");

  done_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    halt_done |=> !halt_done)
    else $error("halt done longer than one cycle");

  target_stable_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!load_target && !wr_target) |=> $stable(target_position))
    else $error("target changed without load or write");

  ignored_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    refuse |=> ignored_reg)
    else $error("refused halt not flagged");

  ignored_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clr_ignored && !refuse) |=> !ignored_reg)
    else $error("ignored flag not cleared by write");

  thermal_once_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (idle && thermal_shutdown && $past(thermal_shutdown) && !frame_hit) |=> state_reg == ST_IDLE)
    else $error("steady overheat raised a second halt");
endmodule : lin_soft_stop_command
`default_nettype wire

/* test/lin_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
module lin_master_model (
  input wire logic pclk,
  output logic frame_valid,
  output logic [3:0] frame_byte_count,
  output logic [7:0] frame_data1,
  output logic [7:0] frame_data2
);
  initial begin
    frame_valid = 1'b0;
    frame_byte_count = 4'h0;
    frame_data1 = 8'h00;
    frame_data2 = 8'h00;
  end
  // Identifier already mapped to the two-byte general pointer, so only data reaches the slave
  task automatic send(input logic [7:0] d1, input logic [7:0] d2, input logic [3:0] cnt);
    @(posedge pclk);
    frame_valid <= 1'b1;
    frame_byte_count <= cnt;
    frame_data1 <= d1;
    frame_data2 <= d2;
    @(posedge pclk);
    frame_valid <= 1'b0;
    // Stale bytes must not look valid after the pulse
    frame_data1 <= ~d1;
    frame_data2 <= ~d2;
  endtask : send
endmodule : lin_master_model
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import halt_cmd_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, frame_valid, decel_to_min, stop_motor, halt_done, acc;
  logic [3:0] frame_byte_count;
  logic [7:0] frame_data1, frame_data2, d2;
  logic thermal_shutdown = 1'b0, two_stage_reference_move = 1'b0, motion_busy = 1'b1, at_min_velocity = 1'b0;
  logic [15:0] actual_position = 16'h1234, target_position, exp_target = 16'h0;
  logic [6:0] node;
  logic [7:0] d1 [6] = '{8'h8f, 8'h8f, 8'h8f, 8'h0f, 8'h8e, 8'h8f};
  integer seed = 32'hff055c7c, num_errors = 0, num_checks = 0;

  always #2.5 pclk = ~pclk;

  lin_soft_stop_command uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .frame_valid, .frame_byte_count, .frame_data1, .frame_data2, .thermal_shutdown,
    .two_stage_reference_move, .motion_busy, .at_min_velocity, .actual_position, .decel_to_min, .stop_motor,
    .halt_done, .target_position);
  lin_master_model lin_master (.pclk, .frame_valid, .frame_byte_count, .frame_data1, .frame_data2);

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16 && pready !== 1'b1; n++) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      num_errors++;
      final_report();
    end
  endtask : apb

  task automatic wait_sig(input int which, output logic seen);
    seen = 1'b0;
    for (int n = 0; n < 8 && seen !== 1'b1; n++) begin
      @(posedge pclk);
      seen = (which == 0) ? decel_to_min : (which == 1) ? stop_motor : halt_done;
    end
  endtask : wait_sig

  task automatic halt_seq(input logic exp_acc);
    logic seen;
    wait_sig(0, seen);
    check("decel", {31'h0, exp_acc}, {31'h0, seen});
    if (exp_acc) begin
      at_min_velocity <= 1'b1;
      wait_sig(1, seen);
      check("stop", 32'h1, {31'h0, seen});
      motion_busy <= 1'b0;
      at_min_velocity <= 1'b0;
      wait_sig(2, seen);
      check("done", 32'h1, {31'h0, seen});
      exp_target = actual_position;
      motion_busy <= 1'b1;
    end
    check("target", {16'h0, exp_target}, {16'h0, target_position});
    $display("test halt expect=%0b finished", exp_acc);
  endtask : halt_seq

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl reset", 32'h100, rd);
    check("ctrl err", 32'h0, {31'h0, err});
    apb(1'b0, ADDR_TARGET, 32'h0);
    check("target reset", 32'h0, rd);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped err", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    node = 7'($random(seed));
    apb(1'b1, ADDR_CTRL, {23'h0, 1'b1, 1'b0, node});
    exp_target = 16'($random(seed));
    apb(1'b1, ADDR_TARGET, {16'h0, exp_target});
    apb(1'b0, ADDR_TARGET, 32'h0);
    check("target rw", {16'h0, exp_target}, rd);
    apb(1'b0, ADDR_ACTUAL, 32'h0);
    check("actual", {16'h0, actual_position}, rd);
    $display("test registers finished");
    for (int i = 0; i < 6; i++) begin
      d2 = (i == 0 || i == 5) ? {1'b0, 7'($random(seed))} : (i == 2) ? {1'b1, node ^ 7'h01} : {1'b1, node};
      actual_position <= 16'($random(seed));
      two_stage_reference_move <= (i == 5);
      lin_master.send(d1[i], d2, 4'h2);
      acc = d1[i] == 8'h8f && (d2[7] == 1'b0 || d2[6:0] == node) && i != 5;
      halt_seq(acc);
    end
    two_stage_reference_move <= 1'b0;
    apb(1'b1, ADDR_CTRL, {23'h0, 1'b0, 1'b0, node});
    lin_master.send(8'h8f, 8'h00, 4'h2);
    halt_seq(1'b0);
    apb(1'b1, ADDR_CTRL, {23'h0, 1'b1, 1'b0, node});
    lin_master.send(8'h8f, 8'h00, 4'h3);
    halt_seq(1'b0);
    motion_busy <= 1'b0;
    lin_master.send(8'h8f, 8'h00, 4'h2);
    halt_seq(1'b0);
    motion_busy <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("status ignored", 32'h500, rd);
    apb(1'b1, ADDR_STATUS, 32'h100);
    thermal_shutdown <= 1'b1;
    halt_seq(1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("status thermal", 32'h610, rd);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
